// ### rtl/addr_decoder_pkg.sv
//////////////////////////////////////////////////////////////////////////////////////////////////////////////
// Purpose: shared constants and carriers for the system address decoder
// Assumes: 32-bit byte addresses, one access in flight at a time
// Notes:   window table bounds are inclusive; the index is the window id
//////////////////////////////////////////////////////////////////////////////////////////////////////////////
package addr_decoder_pkg;

   // address regions, top three bits of the address
   localparam logic [2:0] REGION_CODE = 3'h0;
   localparam logic [2:0] REGION_SRAM = 3'h1;
   localparam logic [2:0] REGION_PERIPH = 3'h2;
   localparam logic [2:0] REGION_INTERNAL = 3'h7;

   // bit-band bases; alias space is 32 MB, band space 1 MB
   localparam logic [31:0] SRAM_BAND_BASE = 32'h2000_0000;
   localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
   localparam logic [31:0] PERIPH_BAND_BASE = 32'h4000_0000;
   localparam logic [31:0] PERIPH_ALIAS_BASE = 32'h4200_0000;
   localparam int ALIAS_SPAN_BITS = 25;

   // region-wide system bus spans with no finer window
   localparam logic [31:0] EXT_PERIPH_LO = 32'ha000_0000;
   localparam logic [31:0] EXT_PERIPH_HI = 32'hdfff_ffff;
   localparam logic [31:0] SYS_HIGH_LO = 32'he010_0000;

   // decoded windows
   localparam int NUM_WIN = 24;
   localparam logic [31:0] WIN_LO [NUM_WIN] = '{
      32'h0000_0000, 32'h1fff_8000, 32'h2000_0000, 32'h4000_4000, 32'h4000_4300, 32'h4000_4500,
      32'h4000_4700, 32'h4000_4800, 32'h4000_4900, 32'h4000_4e00, 32'h4000_4f00, 32'h4000_5000,
      32'h4000_5300, 32'h4000_5400, 32'h4000_5800, 32'h4000_6000, 32'h4000_6400, 32'h4000_7000,
      32'h4000_8000, 32'h4000_a000, 32'h4001_0000, 32'h6000_0000, 32'h8000_0000, 32'he000_0000};
   localparam logic [31:0] WIN_HI [NUM_WIN] = '{
      32'h0003_ffff, 32'h1fff_ffff, 32'h2000_7fff, 32'h4000_42ff, 32'h4000_43ff, 32'h4000_45ff,
      32'h4000_47ff, 32'h4000_48ff, 32'h4000_49ff, 32'h4000_4eff, 32'h4000_4fff, 32'h4000_51ff,
      32'h4000_530f, 32'h4000_54ff, 32'h4000_5fff, 32'h4000_60ff, 32'h4000_6fff, 32'h4000_7fff,
      32'h4000_87ff, 32'h4000_a400, 32'h4001_ffff, 32'h60ff_ffff, 32'h8000_7fff, 32'he00f_ffff};
   localparam logic [4:0] WIN_EXT_MEM_CTRL = 5'h0d;
   localparam logic [4:0] WIN_EXT_MEM = 5'h15;
   localparam logic [4:0] WIN_PPB = 5'h17;
   localparam logic [4:0] WIN_EXT_PERIPH = 5'h18;
   localparam logic [4:0] WIN_SYS_HIGH = 5'h19;
   localparam logic [4:0] WIN_NONE = 5'h1f;

   // reset values
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   typedef enum logic [1:0] {SIZE_BYTE = 2'h0, SIZE_HALF = 2'h1, SIZE_WORD = 2'h2} size_t;
   typedef enum logic [1:0] {DEST_IFETCH = 2'h0, DEST_CODEDATA = 2'h1, DEST_SYS = 2'h2, DEST_PPB = 2'h3} dest_t;
   typedef enum logic [2:0] {ST_IDLE = 3'h0, ST_BEAT0 = 3'h1, ST_BEAT1 = 3'h3, ST_BBWRITE = 3'h2,
                             ST_RESP = 3'h6} state_t;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic write;
      size_t size;
      logic fetch;
      logic [31:0] wdata;
   } up_req_t;

   typedef struct packed {
      logic done;
      logic err;
      logic [31:0] rdata;
   } up_resp_t;

   typedef struct packed {
      logic valid;
      dest_t dest;
      logic [4:0] win;
      logic [31:0] addr;
      logic write;
      logic [3:0] strb;
      logic [31:0] wdata;
      logic lock;
      logic fetch;
      logic extWide;
      logic extSync;
   } dn_req_t;

   typedef struct packed {
      logic ack;
      logic err;
      logic [31:0] rdata;
   } dn_resp_t;

endpackage : addr_decoder_pkg

// ### rtl/system_address_decoder.sv
//////////////////////////////////////////////////////////////////////////////////////////////////////////////
// Purpose: decodes master accesses into regions and windows, routes them to the code buses, system bus
//          or internal peripheral bus, splits unaligned accesses and runs bit-band alias accesses
// Assumes: one master request at a time; the selected slave answers with dnResp.ack
// Notes:   a bit-band write is a locked read then write of the target word
//
// Behaviour
// - lowest half gigabyte decodes as program code
// - sram band at 0x20000000, alias at 0x22000000
// - peripheral band at 0x40000000, alias at 0x42000000
// - top half gigabyte: lowest 1 MB decodes as internal peripherals (ppb), the rest goes to system bus
// - alias bit 0 reads/writes one band bit atomically
// - alias read returns zero or one
// - code buses carry only code range accesses
// - data above code, except ppb, uses system bus
// - system bus fetches allowed in sram region
// - 0xE0000000 to 0xE00FFFFF goes to ppb
// - unaligned word and half-word accesses supported
// - two 32K sram blocks around 0x20000000
// - external memory control window 0x40005400-0x400054FF
// - external memory uses 24 bits from 0x60000000
// - external width 8 or 16, fetch allowed
// - external port serves one memory type
//////////////////////////////////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

module system_address_decoder (
   input wire logic mclk,                            // system bus clock
   input wire logic rstn,                            // synchronous reset, active low
   input wire logic ce,                              // clock enable, freezes all state when low
   input wire addr_decoder_pkg::up_req_t upReq,      // master request
   output logic upReady,                             // request taken when high with valid
   output addr_decoder_pkg::up_resp_t upResp,        // master answer, done is a one-cycle pulse
   output addr_decoder_pkg::dn_req_t dnReq,          // request toward the selected slave bus
   input wire addr_decoder_pkg::dn_resp_t dnResp,    // answer from the selected slave bus
   input wire logic extWide,                         // external memory is 16 bits wide when high
   input wire logic extSync                          // external memory is synchronous when high
);
   import addr_decoder_pkg::*;

   //////////////////////////////////////////////////////////////////////////////////////////////////////////
   // bit-band alias recognition and target address
   //////////////////////////////////////////////////////////////////////////////////////////////////////////

   // alias spaces are the 32 MB spans right above each band base plus 0x02000000
   wire logic inSramAlias;
   wire logic inPeriphAlias;
   wire logic isAlias;
   wire logic [24:0] aliasOff;
   wire logic [31:0] bandBase;
   wire logic [31:0] bandWord;
   wire logic [4:0] bandBit;
   assign inSramAlias = (upReq.addr[31:ALIAS_SPAN_BITS] == SRAM_ALIAS_BASE[31:ALIAS_SPAN_BITS]);
   assign inPeriphAlias = (upReq.addr[31:ALIAS_SPAN_BITS] == PERIPH_ALIAS_BASE[31:ALIAS_SPAN_BITS]);
   assign isAlias = inSramAlias | inPeriphAlias;
   assign aliasOff = upReq.addr[24:0];
   assign bandBase = inSramAlias ? SRAM_BAND_BASE : PERIPH_BAND_BASE;
   // offset/32 gives the band byte, offset/4 mod 32 the bit within the word
   assign bandWord = bandBase | {12'h000, aliasOff[24:7], 2'b00};
   assign bandBit = aliasOff[6:2];

   // effective address that the windows are decoded against
   wire logic [31:0] effAddr;
   assign effAddr = isAlias ? bandWord : upReq.addr;

   //////////////////////////////////////////////////////////////////////////////////////////////////////////
   // window decode
   //////////////////////////////////////////////////////////////////////////////////////////////////////////

   // one comparator pair per window; the flash, both sram blocks, the external port windows and the ppb
   // are all entries of the table
   logic [NUM_WIN-1:0] winHit;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_WIN; gi++) begin : g_win
         assign winHit[gi] = (effAddr >= WIN_LO[gi]) && (effAddr <= WIN_HI[gi]);
      end
   endgenerate

   // lowest hit wins; windows do not overlap so this only fixes the encoding
   logic [4:0] winIdx;
   always_comb begin
      winIdx = WIN_NONE;
      for (int i = NUM_WIN - 1; i >= 0; i--) begin
         if (winHit[i]) begin
            winIdx = 5'(i);
         end
      end
   end

   // region level decode of the effective address
   wire logic [2:0] region;
   wire logic inCode;
   wire logic inSramRegion;
   wire logic inPpb;
   wire logic inExtPeriph;
   wire logic inSysHigh;
   assign region = effAddr[31:29];
   assign inCode = (region == REGION_CODE);
   assign inSramRegion = (region == REGION_SRAM);
   assign inPpb = (winIdx == WIN_PPB);
   assign inExtPeriph = (effAddr >= EXT_PERIPH_LO) && (effAddr <= EXT_PERIPH_HI);
   assign inSysHigh = (region == REGION_INTERNAL) && (effAddr >= SYS_HIGH_LO);

   // final window id, including the two region-wide system bus spans
   wire logic [4:0] win;
   assign win = (winIdx != WIN_NONE) ? winIdx :
                inExtPeriph ? WIN_EXT_PERIPH :
                inSysHigh ? WIN_SYS_HIGH : WIN_NONE;

   // bus selection; code range goes to the fetch or data code bus, ppb to its own bus, the rest to sys
   wire dest_t dest;
   assign dest = inCode ? (upReq.fetch ? DEST_IFETCH : DEST_CODEDATA) :
                 inPpb ? DEST_PPB : DEST_SYS;

   // fetches leave the code buses only for the sram region and external memory, which is slower
   wire logic fetchOk;
   assign fetchOk = inCode | inSramRegion | (win == WIN_EXT_MEM);

   // unmapped address, illegal fetch, or a fetch through an alias all answer with error
   wire logic decErr;
   assign decErr = (win == WIN_NONE) | (upReq.fetch & (~fetchOk | isAlias));

   //////////////////////////////////////////////////////////////////////////////////////////////////////////
   // lane placement for unaligned accesses
   //////////////////////////////////////////////////////////////////////////////////////////////////////////

   // an access may straddle two words; it is laid out over a 64-bit double word and split in two beats
   wire logic [1:0] laneOff;
   wire logic [3:0] sizeMask;
   wire logic [7:0] strbWide;
   wire logic [63:0] wdataWide;
   assign laneOff = upReq.addr[1:0];
   assign sizeMask = (upReq.size == SIZE_WORD) ? 4'hf : (upReq.size == SIZE_HALF) ? 4'h3 : 4'h1;
   assign strbWide = {4'h0, sizeMask} << laneOff;
   assign wdataWide = {32'h0000_0000, upReq.wdata} << {laneOff, 3'b000};

   //////////////////////////////////////////////////////////////////////////////////////////////////////////
   // state
   //////////////////////////////////////////////////////////////////////////////////////////////////////////

   state_t state_r, state_nxt;
   dn_req_t dnReq_r, dnReq_nxt;
   logic [1:0] off_r, off_nxt;
   size_t size_r, size_nxt;
   logic write_r, write_nxt;
   logic bitBand_r, bitBand_nxt;
   logic [4:0] bit_r, bit_nxt;
   logic [3:0] strbHi_r, strbHi_nxt;
   logic [31:0] wdataHi_r, wdataHi_nxt;
   logic bitVal_r, bitVal_nxt;
   logic [31:0] lo_r, lo_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic err_r, err_nxt;
   logic extWide_r, extWide_nxt;
   logic extSync_r, extSync_nxt;

   wire logic take;
   assign upReady = ce & (state_r == ST_IDLE);
   assign take = upReady & upReq.valid;

   // read data extraction from the two beats, shifted down and trimmed to the access size
   wire logic [31:0] readMask;
   wire logic [63:0] readPair;
   wire logic [63:0] readShift;
   wire logic [31:0] readVal;
   assign readMask = (size_r == SIZE_WORD) ? 32'hffff_ffff : (size_r == SIZE_HALF) ? 32'h0000_ffff :
                     32'h0000_00ff;
   assign readPair = (state_r == ST_BEAT1) ? {dnResp.rdata, lo_r} : {32'h0000_0000, dnResp.rdata};
   assign readShift = readPair >> {off_r, 3'b000};
   assign readVal = readShift[31:0] & readMask;

   // bit-band extraction and modify
   wire logic bandRead;
   wire logic [31:0] bandBitMask;
   wire logic [31:0] bandModified;
   assign bandRead = dnResp.rdata[bit_r];
   assign bandBitMask = 32'h0000_0001 << bit_r;
   assign bandModified = bitVal_r ? (dnResp.rdata | bandBitMask) : (dnResp.rdata & ~bandBitMask);

   //////////////////////////////////////////////////////////////////////////////////////////////////////////
   // sequencing
   //////////////////////////////////////////////////////////////////////////////////////////////////////////

   // beat0 goes out unless decode fails; beat1 only when the access spills into the next word; a band write adds the
   // write-back beat with lock held so no other master slips between read and write
   always_comb begin
      state_nxt = state_r;
      dnReq_nxt = dnReq_r;
      off_nxt = off_r;
      size_nxt = size_r;
      write_nxt = write_r;
      bitBand_nxt = bitBand_r;
      bit_nxt = bit_r;
      strbHi_nxt = strbHi_r;
      wdataHi_nxt = wdataHi_r;
      bitVal_nxt = bitVal_r;
      lo_nxt = lo_r;
      rdata_nxt = rdata_r;
      err_nxt = err_r;
      extWide_nxt = extWide_r;
      extSync_nxt = extSync_r;
      unique case (state_r)
         ST_IDLE: begin
            // memory type and width only change between accesses
            extWide_nxt = extWide;
            extSync_nxt = extSync;
            if (take) begin
               off_nxt = isAlias ? 2'b00 : laneOff;
               size_nxt = isAlias ? SIZE_WORD : upReq.size;
               write_nxt = upReq.write;
               bitBand_nxt = isAlias;
               bit_nxt = bandBit;
               bitVal_nxt = upReq.wdata[0];
               strbHi_nxt = strbWide[7:4];
               wdataHi_nxt = wdataWide[63:32];
               err_nxt = 1'b0;
               rdata_nxt = RESET_WORD;
               if (decErr) begin
                  err_nxt = 1'b1;
                  state_nxt = ST_RESP;
               end else begin
                  dnReq_nxt.valid = 1'b1;
                  dnReq_nxt.dest = dest;
                  dnReq_nxt.win = win;
                  dnReq_nxt.addr = {effAddr[31:2], 2'b00};
                  dnReq_nxt.write = upReq.write & ~isAlias;
                  dnReq_nxt.strb = isAlias ? 4'hf : strbWide[3:0];
                  dnReq_nxt.wdata = wdataWide[31:0];
                  dnReq_nxt.lock = isAlias & upReq.write;
                  dnReq_nxt.fetch = upReq.fetch;
                  dnReq_nxt.extWide = extWide;
                  dnReq_nxt.extSync = extSync;
                  state_nxt = ST_BEAT0;
               end
            end
         end
         ST_BEAT0: begin
            if (dnResp.ack) begin
               lo_nxt = dnResp.rdata;
               if (dnResp.err) begin
                  dnReq_nxt.valid = 1'b0;
                  dnReq_nxt.lock = 1'b0;
                  err_nxt = 1'b1;
                  state_nxt = ST_RESP;
               end else if (bitBand_r && write_r) begin
                  dnReq_nxt.write = 1'b1;
                  dnReq_nxt.wdata = bandModified;
                  state_nxt = ST_BBWRITE;
               end else if (bitBand_r) begin
                  dnReq_nxt.valid = 1'b0;
                  rdata_nxt = {31'h0000_0000, bandRead};
                  state_nxt = ST_RESP;
               end else if (strbHi_r != 4'h0) begin
                  dnReq_nxt.addr = dnReq_r.addr + 32'h0000_0004;
                  dnReq_nxt.strb = strbHi_r;
                  dnReq_nxt.wdata = wdataHi_r;
                  state_nxt = ST_BEAT1;
               end else begin
                  dnReq_nxt.valid = 1'b0;
                  rdata_nxt = write_r ? RESET_WORD : readVal;
                  state_nxt = ST_RESP;
               end
            end
         end
         ST_BEAT1: begin
            if (dnResp.ack) begin
               dnReq_nxt.valid = 1'b0;
               err_nxt = dnResp.err;
               rdata_nxt = (write_r || dnResp.err) ? RESET_WORD : readVal;
               state_nxt = ST_RESP;
            end
         end
         ST_BBWRITE: begin
            if (dnResp.ack) begin
               dnReq_nxt.valid = 1'b0;
               dnReq_nxt.lock = 1'b0;
               err_nxt = dnResp.err;
               state_nxt = ST_RESP;
            end
         end
         ST_RESP: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   //////////////////////////////////////////////////////////////////////////////////////////////////////////
   // registers
   //////////////////////////////////////////////////////////////////////////////////////////////////////////

   // control state and the outgoing request
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
         dnReq_r <= '0;
         err_r <= 1'b0;
         rdata_r <= RESET_WORD;
      end else if (ce) begin
         state_r <= state_nxt;
         dnReq_r <= dnReq_nxt;
         err_r <= err_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // captured request attributes and beat data
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         off_r <= 2'b00;
         size_r <= SIZE_BYTE;
         write_r <= 1'b0;
         bitBand_r <= 1'b0;
         bit_r <= 5'h00;
         strbHi_r <= 4'h0;
         wdataHi_r <= RESET_WORD;
         bitVal_r <= 1'b0;
         lo_r <= RESET_WORD;
      end else if (ce) begin
         off_r <= off_nxt;
         size_r <= size_nxt;
         write_r <= write_nxt;
         bitBand_r <= bitBand_nxt;
         bit_r <= bit_nxt;
         strbHi_r <= strbHi_nxt;
         wdataHi_r <= wdataHi_nxt;
         bitVal_r <= bitVal_nxt;
         lo_r <= lo_nxt;
      end
   end

   // external memory configuration, held steady while an access runs
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         extWide_r <= 1'b0;
         extSync_r <= 1'b0;
      end else if (ce) begin
         extWide_r <= extWide_nxt;
         extSync_r <= extSync_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////////////////
   // outputs
   //////////////////////////////////////////////////////////////////////////////////////////////////////////

   // done pulses for the one resp cycle; data and error come from flip-flops
   assign upResp.done = (state_r == ST_RESP);
   assign upResp.err = err_r;
   assign upResp.rdata = rdata_r;
   assign dnReq = dnReq_r;

endmodule : system_address_decoder

// ### dv/system_address_decoder_assertions.sv
// Purpose: port-level checks of routing, windows, bit-band and error answers
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to every instance of the decoder
`timescale 1ns/1ps
module system_address_decoder_checker import addr_decoder_pkg::*; (
   input wire logic mclk, // clock
   input wire logic rstn, // reset, active low
   input wire logic ce, // clock enable
   input wire addr_decoder_pkg::up_req_t upReq, // master request
   input wire logic upReady, // request can be taken
   input wire addr_decoder_pkg::up_resp_t upResp, // master answer
   input wire addr_decoder_pkg::dn_req_t dnReq, // slave beat
   input wire addr_decoder_pkg::dn_resp_t dnResp, // slave answer
   input wire logic extWide, // external width
   input wire logic extSync // external memory type
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic aliasRd_r;
   // remember an alias read, its answer only shows at done
   always_ff @(posedge mclk) begin
      if (!rstn) aliasRd_r <= 1'b0;
      else if (upReq.valid && upReady) aliasRd_r <= !upReq.write && upReq.addr[31:25] inside {7'h11, 7'h21};
   end
   //////////////////////////////////////////////////////////////////////////////////////////////////////////
   chk_code_range: assert property (dnReq.valid && dnReq.dest inside {DEST_IFETCH, DEST_CODEDATA}
      |-> dnReq.addr[31:29] == 3'h0) else $error("code bus beat outside code region");
   chk_ppb_range: assert property (dnReq.valid && dnReq.dest == DEST_PPB
      |-> dnReq.addr[31:20] == 12'he00) else $error("internal bus beat outside its range");
   chk_sys_range: assert property (dnReq.valid && dnReq.dest == DEST_SYS
      |-> dnReq.addr[31:29] != 3'h0 && dnReq.addr[31:20] != 12'he00) else $error("system bus beat misrouted");
   chk_sys_fetch: assert property (dnReq.valid && dnReq.fetch && dnReq.dest == DEST_SYS
      |-> dnReq.addr[31:29] == 3'h1 || dnReq.addr[31:24] == 8'h60) else $error("fetch outside allowed span");
   chk_ext_window: assert property (dnReq.valid && dnReq.win == WIN_EXT_MEM
      |-> dnReq.addr[31:24] == 8'h60) else $error("external window beyond 24 address bits");
   chk_lock_order: assert property (dnReq.valid && dnReq.lock && $rose(dnReq.write)
      |-> $past(dnReq.valid && dnReq.lock && !dnReq.write)) else $error("band write without locked read");
   chk_unmapped_err: assert property (upReq.valid && upReady && upReq.addr[31:24] == 8'h50
      |=> upResp.done && upResp.err && !dnReq.valid) else $error("unmapped access not refused");
   chk_bit_value: assert property (upResp.done && !upResp.err && aliasRd_r
      |-> upResp.rdata[31:1] == 31'h0) else $error("alias read not zero or one");
endmodule : system_address_decoder_checker

bind system_address_decoder system_address_decoder_checker system_address_decoder_checker_i (.mclk(mclk),
   .rstn(rstn), .ce(ce), .upReq(upReq), .upReady(upReady), .upResp(upResp), .dnReq(dnReq), .dnResp(dnResp),
   .extWide(extWide), .extSync(extSync));

// ### dv/bus_slave_model.sv
// Purpose: memory-like slave behind every decoder bus
// Assumes: one beat at a time, ack is a one-cycle pulse
// Notes:   rdata toggles outside acks so stale data never matches
`timescale 1ns/1ps
module bus_slave_model import addr_decoder_pkg::*; (
   input wire logic mclk, // clock
   input wire logic rstn, // reset, active low
   input wire addr_decoder_pkg::dn_req_t dnReq, // beat from decoder
   input wire logic [3:0] lat, // wait cycles before ack
   input wire logic errOn, // answer beats with error
   output addr_decoder_pkg::dn_resp_t dnResp // beat answer
);
   logic [31:0] mem [logic [31:0]];
   logic [31:0] word;
   logic [3:0] waitR;
   initial dnResp = '0;
   // ack after lat cycles; errored writes leave memory alone
   always @(posedge mclk) begin
      word = mem.exists(dnReq.addr) ? mem[dnReq.addr] : 32'h0;
      dnResp.ack <= 1'b0;
      dnResp.err <= 1'b0;
      dnResp.rdata <= ~dnResp.rdata;
      if (!rstn) begin
         dnResp <= '0;
         waitR <= 4'h0;
      end else if (dnReq.valid && !dnResp.ack) begin
         if (waitR < lat) waitR <= waitR + 4'h1;
         else begin
            waitR <= 4'h0;
            dnResp <= '{1'b1, errOn, word};
            for (int b = 0; b < 4; b++) if (dnReq.write && !errOn && dnReq.strb[b]) word[8*b+:8] = dnReq.wdata[8*b+:8];
            mem[dnReq.addr] = word;
         end
      end
   end
endmodule : bus_slave_model

// ### dv/system_address_decoder_tb_top.sv
// Purpose: self-checking bench for the system address decoder
// Assumes: master drives 1 ns after the rising edge
// Notes:   slave latency is raised for the split accesses
`timescale 1ns/1ps
module system_address_decoder_tb_top;
   import addr_decoder_pkg::*;
   logic mclk, rstn, ce, extWide, extSync, upReady, errOn;
   logic [3:0] lat;
   logic [31:0] rd;
   logic rerr;
   up_req_t upReq;
   up_resp_t upResp;
   dn_req_t dnReq;
   dn_resp_t dnResp;
   dn_req_t beats [$];
   int err_count, comparisons;

   system_address_decoder system_address_decoder_i (.mclk(mclk), .rstn(rstn), .ce(ce), .upReq(upReq),
      .upReady(upReady), .upResp(upResp), .dnReq(dnReq), .dnResp(dnResp), .extWide(extWide), .extSync(extSync));
   bus_slave_model bus_slave_model_i (.mclk(mclk), .rstn(rstn), .dnReq(dnReq), .lat(lat), .errOn(errOn),
      .dnResp(dnResp));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // log every finished beat
   always @(posedge mclk) if (dnReq.valid && dnResp.ack) beats.push_back(dnReq);
   //////////////////////////////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one master access, held until taken, result kept in rd and rerr
   task automatic access(input logic [31:0] a, input logic w, input size_t s, input logic f, input logic [31:0] d);
      int i;
      beats.delete();
      upReq <= '{1'b1, a, w, s, f, d};
      while (upReady !== 1'b1) @(posedge mclk) #1;
      @(posedge mclk) #1;
      upReq.valid <= 1'b0;
      for (i = 0; i < 60 && upResp.done !== 1'b1; i++) @(posedge mclk) #1;
      check(upResp.done, 1'b1);
      rd = upResp.rdata;
      rerr = upResp.err;
   endtask : access
   task automatic route(input logic [31:0] a, input logic f, input dest_t ds, input logic [4:0] wn);
      access(a, 1'b0, SIZE_WORD, f, 32'h0);
      check({rerr, 31'(beats.size())}, 32'h1);
      check({beats[0].dest, beats[0].win}, {ds, wn});
      check({beats[0].fetch, beats[0].extWide, beats[0].extSync}, {f, extWide, extSync});
   endtask : route
   task automatic bad(input logic [31:0] a, input logic f);
      access(a, 1'b0, SIZE_WORD, f, 32'h0);
      check({rerr, 31'(beats.size())}, 32'h8000_0000);
      check(rd, 32'h0);
   endtask : bad
   //////////////////////////////////////////////////////////////////////////////////////////////////////////
   task automatic t_routes;
      route(32'h0000_0100, 1'b1, DEST_IFETCH, 5'h00);
      route(32'h0000_0100, 1'b0, DEST_CODEDATA, 5'h00);
      route(32'h1fff_8004, 1'b0, DEST_CODEDATA, 5'h01);
      route(32'h2000_0010, 1'b1, DEST_SYS, 5'h02);
      route(32'h4000_5400, 1'b0, DEST_SYS, WIN_EXT_MEM_CTRL);
      route(32'h6000_0020, 1'b1, DEST_SYS, WIN_EXT_MEM);
      extWide = 1'b0;
      extSync = 1'b1;
      route(32'ha000_0000, 1'b0, DEST_SYS, WIN_EXT_PERIPH);
      route(32'he000_0100, 1'b0, DEST_PPB, WIN_PPB);
      route(32'he010_0000, 1'b0, DEST_SYS, WIN_SYS_HIGH);
   endtask : t_routes
   task automatic t_errors;
      bad(32'h5000_0000, 1'b0);
      bad(32'h4000_4400, 1'b0);
      bad(32'h4000_4000, 1'b1);
      bad(32'h2200_0000, 1'b1);
      bad(32'h8000_8000, 1'b0);
      errOn = 1'b1;
      access(32'h2000_0000, 1'b0, SIZE_WORD, 1'b0, 32'h0);
      check({rerr, 31'(beats.size())}, 32'h8000_0001);
      errOn = 1'b0;
   endtask : t_errors
   task automatic t_bitband;
      access(32'h2000_0000, 1'b1, SIZE_WORD, 1'b0, 32'h0000_00f0);
      access(32'h2200_000c, 1'b1, SIZE_WORD, 1'b0, 32'h1);
      check({beats[0].lock, beats[0].write, beats[1].lock, beats[1].write}, 4'hb);
      check(beats[1].wdata, 32'h0000_00f8);
      access(32'h2200_0010, 1'b1, SIZE_WORD, 1'b0, 32'h0);
      access(32'h2000_0000, 1'b0, SIZE_WORD, 1'b0, 32'h0);
      check(rd, 32'h0000_00e8);
      access(32'h2200_000c, 1'b0, SIZE_WORD, 1'b0, 32'h0);
      check(rd, 32'h1);
      access(32'h2200_0000, 1'b0, SIZE_WORD, 1'b0, 32'h0);
      check(rd, 32'h0);
      access(32'h420a_8008, 1'b1, SIZE_WORD, 1'b0, 32'h1);
      access(32'h4000_5400, 1'b0, SIZE_WORD, 1'b0, 32'h0);
      check(rd, 32'h4);
   endtask : t_bitband
   task automatic t_unaligned;
      access(32'h2000_0100, 1'b1, SIZE_WORD, 1'b0, 32'h3322_1100);
      access(32'h2000_0104, 1'b1, SIZE_WORD, 1'b0, 32'h7766_5544);
      access(32'h2000_0102, 1'b0, SIZE_WORD, 1'b0, 32'h0);
      check(rd, 32'h5544_3322);
      check({beats[0].strb, beats[1].strb}, 8'hc3);
      access(32'h2000_0103, 1'b0, SIZE_HALF, 1'b0, 32'h0);
      check(rd, 32'h4433);
      access(32'h2000_0107, 1'b1, SIZE_HALF, 1'b0, 32'hbbaa);
      access(32'h2000_0104, 1'b0, SIZE_WORD, 1'b0, 32'h0);
      check(rd, 32'haa66_5544);
      access(32'h2000_0108, 1'b0, SIZE_BYTE, 1'b0, 32'h0);
      check(rd, 32'hbb);
   endtask : t_unaligned
   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   //////////////////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      {ce, extWide, extSync, errOn, rstn, lat, upReq} = {5'b11000, 4'h0, 69'h0};
      repeat (10) @(posedge mclk);
      #1 rstn = 1'b1;
      t_routes;
      t_errors;
      t_bitband;
      lat = 4'h3; // slow slave for split beats
      t_unaligned;
      conclude;
   end
   // about 150 cycles expected, cut off at 10000
   initial begin
      #200000;
      err_count++;
      conclude;
   end
endmodule : system_address_decoder_tb_top
